// [rtl/scm_pkg.sv]
package scm_pkg;

    localparam int DIV_W = 16;
    localparam int SYNC_DIV_W = 8;
    localparam int ADDR_W = 8;
    localparam int OVS_W = 4;

    // operation mode field of control register A
    typedef enum logic [2:0] {
        MODE_SER_EXT = 3'h0,
        MODE_SER_INT = 3'h1,
        MODE_SPI_SLV = 3'h2,
        MODE_SPI_MST = 3'h3,
        MODE_I2C_SLV = 3'h4,
        MODE_I2C_MST = 3'h5,
        MODE_RSV6 = 3'h6,
        MODE_RSV7 = 3'h7
    } scm_mode_t;

    // core operating state, one-hot
    typedef enum logic [4:0] {
        ST_OFF = 5'h01,
        ST_HALT = 5'h02,
        ST_ASYNC = 5'h04,
        ST_SYNC_INT = 5'h08,
        ST_SYNC_EXT = 5'h10
    } scm_state_t;

    // fractional baud accumulator: one step adds (2^16 - divisor)
    localparam logic [DIV_W:0] ACC_ONE = 17'h10000;
    localparam logic [OVS_W-1:0] OVS_LAST = 4'hF;

    // seven-bit compares ignore the top address bit
    localparam logic [ADDR_W-1:0] CMP_MASK_7 = 8'h7F;
    localparam logic [ADDR_W-1:0] CMP_MASK_8 = 8'hFF;

    // reset values
    localparam scm_mode_t MODE_RST = MODE_SER_EXT;
    localparam logic [DIV_W-1:0] DIV_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
    localparam logic [ADDR_W-1:0] MASK_RST = 8'h00;

    // frame figures at the reference engine rate (10-bit frame, 16x oversampling)
    localparam int REF_FREQ_HZ = 48000000;
    localparam int FRAME_BITS = 10;
    localparam int OVERSAMPLE = 16;
    localparam int FRAME_CLKS_MIN = FRAME_BITS * OVERSAMPLE;

endpackage

// [rtl/scm_baud_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface scm_baud_if;
    import scm_pkg::*;
    logic run;
    logic sync_mode;
    logic ext_ref;
    logic ref_en;
    logic [DIV_W-1:0] divisor;
    logic tick_x1;
    logic tick_x16;
    logic tick_x2;

    modport gen (
        input run,
        input sync_mode,
        input ext_ref,
        input ref_en,
        input divisor,
        output tick_x1,
        output tick_x16,
        output tick_x2
    );

    modport core (
        output run,
        output sync_mode,
        output ext_ref,
        output ref_en,
        output divisor,
        input tick_x1,
        input tick_x16,
        input tick_x2
    );
endinterface

`default_nettype wire

// [rtl/scm_baud_gen.sv]
`timescale 1ns/1ps
`default_nettype none

module scm_baud_gen
    import scm_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    scm_baud_if.gen bif
);

    logic [DIV_W-1:0] acc_q;
    logic [OVS_W-1:0] ovs_q;
    logic [SYNC_DIV_W-1:0] scnt_q;
    logic tick_x1_q;
    logic tick_x16_q;
    logic tick_x2_q;

    // engine reference is the core clock, or the external clock edge when selected
    wire step_en = bif.run & (~bif.ext_ref | bif.ref_en);
    wire [DIV_W:0] acc_sum = {1'b0, acc_q} + (ACC_ONE - {1'b0, bif.divisor});
    wire [SYNC_DIV_W-1:0] sync_div = bif.divisor[SYNC_DIV_W-1:0];
    wire sync_wrap = (scnt_q == sync_div);

    always_ff @(posedge clk) begin
        if (!rstn || !bif.run) begin
            acc_q <= DIV_RST;
            ovs_q <= '0;
            scnt_q <= '0;
            tick_x1_q <= 1'b0;
            tick_x16_q <= 1'b0;
            tick_x2_q <= 1'b0;
        end else begin
            tick_x1_q <= 1'b0;
            tick_x16_q <= 1'b0;
            tick_x2_q <= 1'b0;
            if (step_en && !bif.sync_mode) begin
                acc_q <= acc_sum[DIV_W-1:0];
                if (acc_sum[DIV_W]) begin
                    tick_x1_q <= 1'b1;
                    ovs_q <= ovs_q + 1'b1;
                    tick_x16_q <= (ovs_q == OVS_LAST);
                end
            end
            if (step_en && bif.sync_mode) begin
                scnt_q <= sync_wrap ? '0 : scnt_q + 1'b1;
                tick_x2_q <= sync_wrap;
            end
        end
    end

    assign bif.tick_x1 = tick_x1_q;
    assign bif.tick_x16 = tick_x16_q;
    assign bif.tick_x2 = tick_x2_q;

endmodule

`default_nettype wire

// [rtl/scm_addr_match.sv]
`timescale 1ns/1ps
`default_nettype none

module scm_addr_match
    import scm_pkg::*;
(
    input wire logic [ADDR_W-1:0] match_addr,
    input wire logic [ADDR_W-1:0] match_mask_field,
    input wire logic two_addr,
    input wire logic seven_bit,
    input wire logic [ADDR_W-1:0] rx_addr,
    output logic hit
);

    wire [ADDR_W-1:0] cmp_mask = seven_bit ? CMP_MASK_7 : CMP_MASK_8;
    wire [ADDR_W-1:0] diff_a = (rx_addr ^ match_addr) & cmp_mask;
    wire [ADDR_W-1:0] diff_b = (rx_addr ^ match_mask_field) & cmp_mask;
    // masked bits never take part; all-zero mask is one address, all-ones is any
    wire hit_masked = ((diff_a & ~match_mask_field) == '0);
    wire hit_two = (diff_a == '0) | (diff_b == '0);

    assign hit = two_addr ? hit_two : hit_masked;

endmodule

`default_nettype wire

// [rtl/scm_core.sv]
`timescale 1ns/1ps
`default_nettype none

module scm_core
    import scm_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic soft_reset_trigger,
    input wire logic ctrl_wr,
    input wire logic ctrl_enable,
    input wire logic [2:0] ctrl_mode,
    input wire logic ctrl_comm_mode_select,
    input wire logic ctrl_clock_polarity_select,
    input wire logic divisor_wr,
    input wire logic [DIV_W-1:0] divisor_in,
    input wire logic match_wr,
    input wire logic [ADDR_W-1:0] match_addr_in,
    input wire logic [ADDR_W-1:0] match_mask_field_in,
    input wire logic match_two_addr_in,
    input wire logic match_seven_bit_in,
    input wire logic debug_control_wr,
    input wire logic debug_run_in,
    input wire logic debug_halt,
    input wire logic rx_addr_valid,
    input wire logic [ADDR_W-1:0] rx_addr,
    input wire logic serial_clock_pin_in,
    output logic enabled_q,
    output logic [2:0] mode_status_q,
    output logic sync_status_q,
    output logic reserved_status_q,
    output logic internal_clk_status_q,
    output logic tx_change_en_q,
    output logic rx_sample_en_q,
    output logic serial_clock_pin_out_q,
    output logic serial_clock_pin_oe_q,
    output logic addr_hit_q,
    output logic addr_hit_valid_q,
    output logic debug_run_q
);

    // control register A and friends
    logic enable_q;
    scm_mode_t mode_q;
    logic comm_mode_select_q;
    logic clock_polarity_select_q;
    logic [DIV_W-1:0] divisor_q;
    logic [ADDR_W-1:0] maddr_q;
    logic [ADDR_W-1:0] mmask_q;
    logic two_addr_q;
    logic seven_bit_q;
    logic dbg_run_q;

    scm_state_t state_q;
    scm_state_t state_d;

    // pin synchroniser and filtered level
    logic pin_s1_q;
    logic pin_s2_q;
    logic pin_s3_q;
    logic pin_lvl_q;

    // generated serial clock level
    logic sck_q;

    logic match_hit;

    scm_baud_if bif ();

    // one name per operating state, so no bit of the one-hot code is picked by number
    wire st_off = (state_q == ST_OFF);
    wire st_halt = (state_q == ST_HALT);
    wire st_async = (state_q == ST_ASYNC);
    wire st_sync_int = (state_q == ST_SYNC_INT);
    wire st_sync_ext = (state_q == ST_SYNC_EXT);
    // address compares are answered only while enabled in a usable mode
    wire hit_req = rx_addr_valid & ~st_off & ~st_halt;

    // decode of the mode field
    wire mode_reserved = (mode_q == MODE_RSV6) || (mode_q == MODE_RSV7);
    wire mode_serial = (mode_q == MODE_SER_EXT) || (mode_q == MODE_SER_INT);
    wire mode_internal = (mode_q == MODE_SER_INT) || (mode_q == MODE_SPI_MST)
        || (mode_q == MODE_I2C_MST);
    // SPI and I2C always clock synchronously; plain serial follows the comm mode bit
    wire mode_sync = mode_serial ? comm_mode_select_q : 1'b1;

    // debug halt freezes the engine unless debug control allows running
    wire frozen = debug_halt & ~dbg_run_q;

    // filtered pin: a change counts only once the second and third stages agree
    wire pin_agree = (pin_s2_q == pin_s3_q);
    wire pin_lvl_d = pin_agree ? pin_s3_q : pin_lvl_q;
    wire pin_rise = pin_lvl_d & ~pin_lvl_q;
    wire pin_fall = ~pin_lvl_d & pin_lvl_q;

    // internal serial clock: each divide-by-2 tick flips the level, held while frozen
    wire sck_step = bif.tick_x2 & st_sync_int & ~frozen;
    wire sck_rise = sck_step & ~sck_q;
    wire sck_fall = sck_step & sck_q;

    // edge source per clocking choice
    wire edge_rise = st_sync_int ? sck_rise : pin_rise;
    wire edge_fall = st_sync_int ? sck_fall : pin_fall;
    // change edge and sample edge are always opposite
    wire sync_change = clock_polarity_select_q ? edge_fall : edge_rise;
    wire sync_sample = clock_polarity_select_q ? edge_rise : edge_fall;
    wire sync_run = st_sync_int | st_sync_ext;

    wire tx_change_d = st_async ? bif.tick_x16 : (sync_run & sync_change);
    wire rx_sample_d = st_async ? bif.tick_x1 : (sync_run & sync_sample);

    // pin direction: driven only while running synchronously on the internal clock
    wire pin_oe_d = st_sync_int;
    // idle level equals polarity so the first edge is the change edge
    wire sck_idle = clock_polarity_select_q;
    // next level of the generated clock; the pin takes it at the same edge as the strobes,
    // so a strobe and its pin edge always share one cycle
    wire sck_d = !st_sync_int ? sck_idle : (sck_step ? ~sck_q : sck_q);

    // baud generator hookup
    assign bif.run = (st_async | st_sync_int) & ~frozen;
    assign bif.sync_mode = st_sync_int;
    // async with external clock counts the pin's rising edges as engine reference
    assign bif.ext_ref = st_async & ~mode_internal;
    assign bif.ref_en = pin_rise;
    assign bif.divisor = divisor_q;

    scm_baud_gen u_baud (
        .clk(clk),
        .rstn(rstn),
        .bif(bif)
    );

    scm_addr_match u_match (
        .match_addr(maddr_q),
        .match_mask_field(mmask_q),
        .two_addr(two_addr_q),
        .seven_bit(seven_bit_q),
        .rx_addr(rx_addr),
        .hit(match_hit)
    );

    // operating state follows configuration each cycle
    always_comb begin
        state_d = ST_OFF;
        case (1'b1)
            !enable_q: state_d = ST_OFF;
            mode_reserved: state_d = ST_HALT;
            !mode_sync: state_d = ST_ASYNC;
            mode_internal: state_d = ST_SYNC_INT;
            default: state_d = ST_SYNC_EXT;
        endcase
    end

    // soft reset clears configuration but not debug control
    always_ff @(posedge clk) begin
        if (!rstn || soft_reset_trigger) begin
            enable_q <= 1'b0;
            mode_q <= MODE_RST;
            comm_mode_select_q <= 1'b0;
            clock_polarity_select_q <= 1'b0;
        end else if (ctrl_wr) begin
            enable_q <= ctrl_enable;
            mode_q <= scm_mode_t'(ctrl_mode);
            comm_mode_select_q <= ctrl_comm_mode_select;
            clock_polarity_select_q <= ctrl_clock_polarity_select;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn || soft_reset_trigger) begin
            divisor_q <= DIV_RST;
        end else if (divisor_wr) begin
            divisor_q <= divisor_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn || soft_reset_trigger) begin
            maddr_q <= ADDR_RST;
            mmask_q <= MASK_RST;
            two_addr_q <= 1'b0;
            seven_bit_q <= 1'b0;
        end else if (match_wr) begin
            maddr_q <= match_addr_in;
            mmask_q <= match_mask_field_in;
            two_addr_q <= match_two_addr_in;
            seven_bit_q <= match_seven_bit_in;
        end
    end

    // debug control survives soft reset, only the hard reset clears it
    always_ff @(posedge clk) begin
        if (!rstn) begin
            dbg_run_q <= 1'b0;
        end else if (debug_control_wr) begin
            dbg_run_q <= debug_run_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn || soft_reset_trigger) begin
            state_q <= ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
            pin_lvl_q <= 1'b0;
        end else begin
            pin_s1_q <= serial_clock_pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_lvl_q <= pin_lvl_d;
        end
    end

    // generated clock parks at its idle level whenever not running internally
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sck_q <= 1'b0;
        end else begin
            sck_q <= sck_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            tx_change_en_q <= 1'b0;
            rx_sample_en_q <= 1'b0;
        end else begin
            tx_change_en_q <= tx_change_d & ~frozen;
            rx_sample_en_q <= rx_sample_d & ~frozen;
        end
    end

    // pin takes the next level at the same edge as the strobes
    always_ff @(posedge clk) begin
        if (!rstn) begin
            serial_clock_pin_out_q <= 1'b0;
            serial_clock_pin_oe_q <= 1'b0;
        end else begin
            serial_clock_pin_out_q <= sck_d;
            serial_clock_pin_oe_q <= pin_oe_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            addr_hit_q <= 1'b0;
            addr_hit_valid_q <= 1'b0;
        end else begin
            addr_hit_valid_q <= hit_req;
            addr_hit_q <= hit_req & match_hit;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            enabled_q <= 1'b0;
            mode_status_q <= MODE_RST;
            sync_status_q <= 1'b0;
            reserved_status_q <= 1'b0;
            internal_clk_status_q <= 1'b0;
            debug_run_q <= 1'b0;
        end else begin
            enabled_q <= enable_q;
            mode_status_q <= mode_q;
            sync_status_q <= mode_sync;
            reserved_status_q <= mode_reserved;
            internal_clk_status_q <= mode_internal;
            debug_run_q <= dbg_run_q;
        end
    end

endmodule

`default_nettype wire

// [test/scm_core_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module scm_core_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic soft_reset_trigger,
    input wire logic ctrl_wr,
    input wire logic divisor_wr,
    input wire logic rx_addr_valid,
    input wire logic enabled_q,
    input wire logic sync_status_q,
    input wire logic reserved_status_q,
    input wire logic internal_clk_status_q,
    input wire logic tx_change_en_q,
    input wire logic rx_sample_en_q,
    input wire logic serial_clock_pin_out_q,
    input wire logic serial_clock_pin_oe_q,
    input wire logic addr_hit_q,
    input wire logic addr_hit_valid_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [1:0] cfg_q;
    logic armed_q;
    logic [4:0] rx_cnt_q;
    wire [4:0] rx_sum;
    wire idle;
    assign rx_sum = rx_cnt_q + {4'h0, rx_sample_en_q};
    assign idle = !enabled_q || reserved_status_q;
    // ratio only judged between two bit ticks of one unchanged setup
    always_ff @(posedge clk) begin
        cfg_q <= {cfg_q[0], ctrl_wr | divisor_wr | soft_reset_trigger};
        if (!rstn || |cfg_q || cfg_q[0] || !enabled_q || sync_status_q) begin
            armed_q <= 1'b0;
            rx_cnt_q <= 5'h00;
        end else if (tx_change_en_q) begin
            armed_q <= 1'b1;
            rx_cnt_q <= 5'h00;
        end else begin
            rx_cnt_q <= rx_sum;
        end
    end
    chk_hit_cause: assert property (addr_hit_valid_q |-> $past(rx_addr_valid))
        else $error("match answer without request");
    chk_hit_pair: assert property (addr_hit_q |-> addr_hit_valid_q)
        else $error("hit without valid");
    chk_hit_answer: assert property (rx_addr_valid && !idle && !ctrl_wr && !$past(ctrl_wr)
        && !soft_reset_trigger && !$past(soft_reset_trigger) |=> addr_hit_valid_q)
        else $error("match request not answered");
    chk_quiet_idle: assert property (idle && $past(idle)
        |-> !tx_change_en_q && !rx_sample_en_q && !serial_clock_pin_oe_q)
        else $error("activity while idle");
    chk_oe_source: assert property (serial_clock_pin_oe_q
        |-> $past(enabled_q && sync_status_q && internal_clk_status_q))
        else $error("clock pin driven outside internal sync");
    chk_strobe_edge: assert property (serial_clock_pin_oe_q && (tx_change_en_q || rx_sample_en_q)
        |-> serial_clock_pin_out_q != $past(serial_clock_pin_out_q))
        else $error("strobe without pin edge");
    chk_edge_strobe: assert property (serial_clock_pin_oe_q && enabled_q && $past(enabled_q)
        && $changed(serial_clock_pin_out_q) |-> tx_change_en_q ^ rx_sample_en_q)
        else $error("pin edge without one strobe");
    chk_sync_excl: assert property (sync_status_q && $past(sync_status_q)
        |-> !(tx_change_en_q && rx_sample_en_q))
        else $error("change and sample on one edge");
    chk_async_ratio: assert property (tx_change_en_q && armed_q |-> rx_sum == 5'h10)
        else $error("bit tick not every 16 sample ticks");
    chk_sreset_off: assert property (soft_reset_trigger |-> ##2 !enabled_q)
        else $error("soft reset left unit enabled");
    cover property (tx_change_en_q && armed_q);
    cover property (addr_hit_q);
    cover property (serial_clock_pin_oe_q && tx_change_en_q);
endmodule
bind scm_core scm_core_checker i_chk (.clk, .rstn, .soft_reset_trigger, .ctrl_wr, .divisor_wr,
    .rx_addr_valid, .enabled_q, .sync_status_q, .reserved_status_q, .internal_clk_status_q,
    .tx_change_en_q, .rx_sample_en_q, .serial_clock_pin_out_q, .serial_clock_pin_oe_q,
    .addr_hit_q, .addr_hit_valid_q);
`default_nettype wire

// [test/scm_peer.sv]
`timescale 1ns/1ps
`default_nettype none
module scm_peer (
    input wire logic run,
    input wire logic idle_lvl,
    output logic sck
);
    // still between frames at the idle level, phase unrelated to clk
    initial sck = 1'b0;
    always begin
        #23.1;
        sck = run ? ~sck : idle_lvl;
    end
endmodule
`default_nettype wire

// [test/scm_core_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module scm_core_tb;
    import scm_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic soft_reset_trigger, ctrl_wr, ctrl_enable, ctrl_comm_mode_select;
    logic ctrl_clock_polarity_select, divisor_wr, match_wr, match_two_addr_in;
    logic match_seven_bit_in, debug_control_wr, debug_run_in, debug_halt, rx_addr_valid;
    logic peer_run, peer_sck, enabled_q, sync_status_q, reserved_status_q, internal_clk_status_q;
    logic tx_change_en_q, rx_sample_en_q, serial_clock_pin_out_q, serial_clock_pin_oe_q;
    logic addr_hit_q, addr_hit_valid_q, debug_run_q;
    logic [2:0] ctrl_mode, mode_status_q;
    logic [DIV_W-1:0] divisor_in;
    logic [ADDR_W-1:0] match_addr_in, match_mask_field_in, rx_addr;
    wire serial_clock_pin_in;
    logic exp_q[$];
    logic [15:0] rnd = 16'h8631;
    int n_fail = 0;
    int cmp_count = 0;
    int n_tx, n_rx;
    scm_core i_dut (.clk, .rstn, .soft_reset_trigger, .ctrl_wr, .ctrl_enable, .ctrl_mode,
        .ctrl_comm_mode_select, .ctrl_clock_polarity_select, .divisor_wr, .divisor_in, .match_wr,
        .match_addr_in, .match_mask_field_in, .match_two_addr_in, .match_seven_bit_in,
        .debug_control_wr, .debug_run_in, .debug_halt, .rx_addr_valid, .rx_addr,
        .serial_clock_pin_in, .enabled_q, .mode_status_q, .sync_status_q, .reserved_status_q,
        .internal_clk_status_q, .tx_change_en_q, .rx_sample_en_q, .serial_clock_pin_out_q,
        .serial_clock_pin_oe_q, .addr_hit_q, .addr_hit_valid_q, .debug_run_q);
    scm_peer i_peer (.run(peer_run), .idle_lvl(ctrl_clock_polarity_select), .sck(peer_sck));
    assign serial_clock_pin_in = serial_clock_pin_oe_q ? serial_clock_pin_out_q : peer_sck;
    always #2.5 clk = ~clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic stop_test();
        if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic ctrl(input logic en, input logic [2:0] m, input logic cm, input logic cp);
        @(negedge clk);
        {ctrl_wr, ctrl_enable, ctrl_mode, ctrl_comm_mode_select} = {1'b1, en, m, cm};
        ctrl_clock_polarity_select = cp;
        @(negedge clk);
        ctrl_wr = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic set_div(input logic [15:0] d);
        @(negedge clk);
        {divisor_wr, divisor_in} = {1'b1, d};
        @(negedge clk);
        divisor_wr = 1'b0;
    endtask
    task automatic probe(input logic [7:0] a);
        logic [7:0] w;
        logic [7:0] d;
        w = match_seven_bit_in ? 8'h7F : 8'hFF;
        d = (a ^ match_addr_in) & w;
        exp_q.push_back(match_two_addr_in ? (d == 0 || ((a ^ match_mask_field_in) & w) == 0)
            : ((d & ~match_mask_field_in) == 0));
        @(negedge clk);
        {rx_addr_valid, rx_addr} = {1'b1, a};
    endtask
    // windows start just after a change strobe so the strobe counts are exact
    task automatic sync_tx();
        int t;
        t = n_tx;
        for (int i = 0; i < 4000 && n_tx == t; i++) @(negedge clk);
        n_tx = 0;
        n_rx = 0;
    endtask
    always @(posedge clk) begin
        #1;
        if (tx_change_en_q === 1'b1) n_tx++;
        if (rx_sample_en_q === 1'b1) n_rx++;
        if (serial_clock_pin_oe_q === 1'b1 && tx_change_en_q === 1'b1)
            cmp(serial_clock_pin_out_q, !ctrl_clock_polarity_select);
        if (addr_hit_valid_q === 1'b1) begin
            if (exp_q.size() == 0) cmp(1'b1, 1'b0);
            else cmp(addr_hit_q, exp_q.pop_front());
        end
    end
    initial begin
        #400us;
        n_fail++;
        stop_test();
    end
    initial begin
        {soft_reset_trigger, ctrl_wr, ctrl_enable, ctrl_mode, ctrl_comm_mode_select} = '0;
        {ctrl_clock_polarity_select, divisor_wr, divisor_in, match_wr, match_addr_in} = '0;
        {match_mask_field_in, match_two_addr_in, match_seven_bit_in, debug_control_wr} = '0;
        {debug_run_in, debug_halt, rx_addr_valid, rx_addr, peer_run} = '0;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        cmp({enabled_q, mode_status_q, serial_clock_pin_oe_q, debug_run_q}, 0);
        for (int m = 0; m < 8; m++) begin
            rnd = lfsr(rnd);
            ctrl(1'b1, 3'(m), rnd[0], 1'b0);
            {n_tx, n_rx} = '0;
            repeat (20) @(negedge clk);
            cmp({enabled_q, mode_status_q, reserved_status_q, internal_clk_status_q},
                {1'b1, 3'(m), m > 5, m % 2 == 1 && m < 6});
            if (m < 6) cmp(sync_status_q, m < 2 ? rnd[0] : 1'b1);
            else cmp(n_tx + n_rx, 0);
            ctrl(1'b0, 3'(m), 1'b0, 1'b0);
            cmp(enabled_q, 1'b0);
        end
        ctrl(1'b1, MODE_I2C_SLV, 1'b0, 1'b0);
        for (int k = 0; k < 16; k++) begin
            rnd = lfsr(rnd);
            @(negedge clk);
            {match_wr, match_addr_in} = {1'b1, rnd[7:0]};
            {match_two_addr_in, match_seven_bit_in} = {k[0], k[1]};
            match_mask_field_in = k < 4 ? 8'h00 : k < 8 ? 8'hFF : rnd[15:8];
            @(negedge clk);
            match_wr = 1'b0;
            repeat (2) @(negedge clk);
            for (int j = 0; j < 6; j++) begin
                rnd = lfsr(rnd);
                probe(j == 0 ? match_addr_in : j == 1 ? match_mask_field_in
                    : rnd[7:0] ^ 8'(j == 2));
            end
            @(negedge clk);
            rx_addr_valid = 1'b0;
        end
        ctrl(1'b0, MODE_I2C_SLV, 1'b0, 1'b0);
        probe(8'h00);
        void'(exp_q.pop_back());
        @(negedge clk);
        rx_addr_valid = 1'b0;
        for (int p = 0; p < 2; p++) begin
            set_div(16'hAB03);
            ctrl(1'b1, MODE_SER_INT, 1'b1, 1'(p));
            sync_tx();
            repeat (80) @(negedge clk);
            cmp(n_tx, 10);
            cmp(n_rx, 10);
            ctrl(1'b0, MODE_SER_INT, 1'b1, 1'(p));
            cmp({serial_clock_pin_oe_q, serial_clock_pin_out_q}, {1'b0, 1'(p)});
        end
        set_div(16'h0000);
        ctrl(1'b1, MODE_SER_INT, 1'b0, 1'b0);
        sync_tx();
        repeat (160) @(negedge clk);
        cmp(n_tx, 10);
        cmp(n_rx, 160);
        set_div(16'hFEB8);
        sync_tx();
        repeat (31969) @(negedge clk);
        cmp(n_tx, 10);
        ctrl(1'b0, MODE_SER_INT, 1'b0, 1'b0);
        ctrl(1'b1, MODE_SER_EXT, 1'b1, 1'b0);
        {n_tx, n_rx} = '0;
        peer_run = 1'b1;
        repeat (16) @(peer_sck);
        peer_run = 1'b0;
        repeat (20) @(negedge clk);
        cmp(n_tx, 8);
        cmp(n_rx, 8);
        cmp(serial_clock_pin_oe_q, 1'b0);
        set_div(16'h0000);
        ctrl(1'b1, MODE_SER_EXT, 1'b0, 1'b0);
        {n_tx, n_rx} = '0;
        peer_run = 1'b1;
        repeat (32) @(peer_sck);
        peer_run = 1'b0;
        repeat (20) @(negedge clk);
        cmp(n_tx, 1);
        cmp(n_rx, 16);
        @(negedge clk);
        {debug_control_wr, debug_run_in} = 2'h3;
        @(negedge clk);
        debug_control_wr = 1'b0;
        ctrl(1'b1, MODE_SPI_MST, 1'b1, 1'b1);
        @(negedge clk);
        soft_reset_trigger = 1'b1;
        @(negedge clk);
        soft_reset_trigger = 1'b0;
        repeat (3) @(negedge clk);
        cmp({enabled_q, mode_status_q, serial_clock_pin_oe_q, debug_run_q},
            {1'b0, MODE_RST, 2'h1});
        cmp(exp_q.size(), 0);
        stop_test();
    end
endmodule
`default_nettype wire
